//--- can_buffer_flags.sv
// can_buffer_flags: receive/transmit buffer flags, enables, abort handshake, acceptance mode
// assumes: avalon-mm master on mclk, protocol engine gives one-cycle event pulses on mclk
//
// Functional notes
// - overrun sets overrun flag; with enable it holds error interrupt pending
// - stored accepted message sets receive-full flag
// - no background-to-foreground copy while receive-full is set
// - soft-reset bit holds flag, enable and transmit control registers reset
// - receive enables route wakeup, error and receive-full events to interrupts
// - abort ack read-only; empty flags write-one-clear; resets restore flags
// - successful transmission sets the buffer's empty flag
// - granted abort sets empty and ack flags, raising enabled interrupt
// - clearing an empty flag clears its ack flag too
// - abort granted only before start or after failed transmission
// - abort request settable only; cleared when empty flag sets
// - empty interrupt enables route each buffer to transmit interrupt
// - acceptance mode selects filter layout; closed mode accepts nothing
// - hit field reports which filter accepted the message
// - hit field updates when message is copied to foreground
// - acceptance control writable only while soft-reset bit is set
// - receive flags clear on one, only once their cause has gone
// - accept only when all unmasked identifier bits equal the code
`timescale 1ns/1ns
`default_nettype none

module can_buffer_flags
	import can_flags_pkg::*;
#(
	parameter int DATA_W = 32
) (
	// clock, reset, enable
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clkEn,
	// avalon-mm slave
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [DATA_W-1:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [DATA_W-1:0] readdata,
	output logic waitrequest,
	// protocol engine side
	input wire can_events_s events,
	input wire can_causes_s causes,
	input wire logic idMatch,
	output logic softResetMode,
	output logic [2:0] abortRequest,
	output logic [1:0] acceptanceMode,
	output logic foregroundLoad,
	// interrupts
	output can_irqs_s irqs
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	bus_state_e busState_reg;
	logic [7:0] rxFlags_reg;
	logic [7:0] rxIrqEn_reg;
	logic [2:0] txEmpty_reg;
	logic [2:0] abortAck_reg;
	logic [2:0] abortReq_reg;
	logic [2:0] txIrqEn_reg;
	logic [1:0] accMode_reg;
	logic [1:0] hit_reg;
	logic softReset_reg;
	logic waitrequest_reg;
	logic load_reg;
	logic [DATA_W-1:0] readdata_reg;
	can_irqs_s irqs_reg;

	logic grp;
	logic wrStrobe;
	logic wrLow;
	logic [7:0] wrByte;
	logic [7:0] rxCause;
	logic [7:0] rxFlags_next;
	logic [2:0] txEmpty_next;
	logic [2:0] abortGrant;
	logic accept;
	logic [DATA_W-1:0] readdata_next;

	function automatic logic hit_addr(input logic [4:0] a, input logic g, input logic [3:0] o);
		hit_addr = (a[ADDR_GROUP_BIT] == g) && (a[3:0] == o);
	endfunction

	// ----------------------------------------------------------------
	// bus slave: one wait cycle, then answer
	// ----------------------------------------------------------------
	assign wrStrobe = write && busState_reg == BUS_ANSWER;
	assign wrLow = wrStrobe && byteenable[0];
	assign wrByte = writedata[7:0];
	assign grp = address[ADDR_GROUP_BIT];

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			busState_reg <= BUS_IDLE;
			waitrequest_reg <= 1'b1;
		end else if (clkEn) begin
			if (busState_reg == BUS_IDLE && (read || write)) begin
				busState_reg <= BUS_ANSWER;
				waitrequest_reg <= 1'b0;
			end else begin
				busState_reg <= BUS_IDLE;
				waitrequest_reg <= 1'b1;
			end
		end
	end

	assign waitrequest = waitrequest_reg;

	// ----------------------------------------------------------------
	// module control: soft reset bit
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			softReset_reg <= MOD_SOFT_RESET_VALUE;
		end else if (clkEn && wrLow && hit_addr(address, 1'b1, ADDR_MOD_CTRL)) begin
			softReset_reg <= wrByte[MOD_SOFT_RESET];
		end
	end

	// ----------------------------------------------------------------
	// receive flags and enables
	// ----------------------------------------------------------------
	assign rxCause = {causes.wakeup, causes.rxWarning, causes.txWarning, causes.rxPassive,
		causes.txPassive, causes.busOff, 1'b0, 1'b0};
	// message is accepted only when filter matches and mode is open
	assign accept = events.msgReceived && idMatch && accMode_reg != MODE_CLOSED;
	// copy only while foreground free
	assign foregroundLoad = load_reg;

	always_comb begin
		rxFlags_next = rxFlags_reg;
		if (wrLow && hit_addr(address, 1'b0, ADDR_RX_FLAGS)) begin
			// clear only bits whose cause has gone
			rxFlags_next = rxFlags_reg & ~(wrByte & ~rxCause);
		end
		// set wins over clear
		rxFlags_next = rxFlags_next | {events.wakeup, events.rxWarning, events.txWarning,
			events.rxPassive, events.txPassive, events.busOff, 1'b0, 1'b0};
		if (events.overrun || (accept && rxFlags_reg[RXF_FULL])) begin
			rxFlags_next[RXF_OVERRUN] = 1'b1;
		end
		if (accept && !rxFlags_reg[RXF_FULL]) begin
			rxFlags_next[RXF_FULL] = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst || softReset_reg) begin
			rxFlags_reg <= RX_FLAGS_RESET;
			load_reg <= 1'b0;
			hit_reg <= HIT_RESET;
		end else if (clkEn) begin
			rxFlags_reg <= rxFlags_next;
			load_reg <= accept && !rxFlags_reg[RXF_FULL];
			if (accept && !rxFlags_reg[RXF_FULL]) begin
				hit_reg <= events.msgHit;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst || softReset_reg) begin
			rxIrqEn_reg <= RX_IRQ_EN_RESET;
		end else if (clkEn && wrLow && hit_addr(address, 1'b0, ADDR_RX_IRQ_EN)) begin
			rxIrqEn_reg <= wrByte;
		end
	end

	// ----------------------------------------------------------------
	// transmit flags, abort handshake, transmit control
	// ----------------------------------------------------------------
	// engine reports abortable when not started or after a failed attempt
	assign abortGrant = abortReq_reg & ~txEmpty_reg & events.txAbortable;

	always_comb begin
		txEmpty_next = txEmpty_reg;
		if (wrLow && hit_addr(address, 1'b0, ADDR_TX_FLAGS)) begin
			txEmpty_next = txEmpty_reg & ~wrByte[2:0];
		end
		txEmpty_next = txEmpty_next | events.txDone | abortGrant;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst || softReset_reg) begin
			txEmpty_reg <= TX_EMPTY_RESET;
			abortAck_reg <= TX_ZERO_RESET;
		end else if (clkEn) begin
			txEmpty_reg <= txEmpty_next;
			// ack cleared with its empty flag; grant sets it
			abortAck_reg <= ((abortAck_reg & txEmpty_next) & ~events.txDone) | abortGrant;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst || softReset_reg) begin
			abortReq_reg <= TX_ZERO_RESET;
			txIrqEn_reg <= TX_ZERO_RESET;
		end else if (clkEn) begin
			if (wrLow && hit_addr(address, 1'b0, ADDR_TX_CTRL)) begin
				// request only settable, cleared when empty sets
				abortReq_reg <= (abortReq_reg | wrByte[TXC_REQ_LSB +: 3]) & ~txEmpty_next;
				txIrqEn_reg <= wrByte[2:0];
			end else begin
				abortReq_reg <= abortReq_reg & ~txEmpty_next;
			end
		end
	end

	assign abortRequest = abortReq_reg;

	// ----------------------------------------------------------------
	// acceptance control
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			accMode_reg <= ACC_MODE_RESET;
		end else if (clkEn && wrLow && softReset_reg && hit_addr(address, 1'b1, ADDR_ACC_CTRL)) begin
			accMode_reg <= wrByte[ACC_MODE_LSB +: 2];
		end
	end

	assign acceptanceMode = accMode_reg;
	assign softResetMode = softReset_reg;

	// ----------------------------------------------------------------
	// interrupt requests
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			irqs_reg <= '0;
		end else if (clkEn) begin
			irqs_reg.wakeupIrq <= rxFlags_next[RXF_WAKEUP] && rxIrqEn_reg[RXF_WAKEUP];
			irqs_reg.errorIrq <= |(rxFlags_next[6:1] & rxIrqEn_reg[6:1]);
			irqs_reg.rxIrq <= rxFlags_next[RXF_FULL] && rxIrqEn_reg[RXF_FULL];
			irqs_reg.txIrq <= |(txEmpty_next & txIrqEn_reg);
			if (softReset_reg) begin
				irqs_reg <= '0;
			end
		end
	end

	assign irqs = irqs_reg;

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	always_comb begin
		readdata_next = UNMAPPED_READ;
		unique case ({grp, address[3:0]})
			{1'b0, ADDR_RX_FLAGS}: readdata_next[7:0] = rxFlags_reg;
			{1'b0, ADDR_RX_IRQ_EN}: readdata_next[7:0] = rxIrqEn_reg;
			{1'b0, ADDR_TX_FLAGS}: readdata_next[7:0] = {1'b0, abortAck_reg, 1'b0, txEmpty_reg};
			{1'b0, ADDR_TX_CTRL}: readdata_next[7:0] = {1'b0, abortReq_reg, 1'b0, txIrqEn_reg};
			{1'b1, ADDR_ACC_CTRL}: readdata_next[7:0] = {2'b00, accMode_reg, 2'b00, hit_reg};
			{1'b1, ADDR_MOD_CTRL}: readdata_next[7:0] = {7'h00, softReset_reg};
			{1'b1, ADDR_IRQ_STATUS}: readdata_next[7:0] = {4'h0, irqs_reg};
			default: readdata_next = UNMAPPED_READ;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			readdata_reg <= UNMAPPED_READ;
		end else if (clkEn && read && busState_reg == BUS_IDLE) begin
			readdata_reg <= readdata_next;
		end
	end

	assign readdata = readdata_reg;

endmodule

`default_nettype wire

//--- can_flags_pkg.sv
// package: register map, field positions and reset values of the can buffer flag block
// assumes: 8-bit registers, each on its own 32-bit avalon word
package can_flags_pkg;

	// ----------------------------------------------------------------
	// register byte addresses
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_RX_FLAGS = 4'h0;
	localparam logic [3:0] ADDR_RX_IRQ_EN = 4'h4;
	localparam logic [3:0] ADDR_TX_FLAGS = 4'h8;
	localparam logic [3:0] ADDR_TX_CTRL = 4'hC;
	localparam logic [3:0] ADDR_ACC_CTRL = 4'h0;
	localparam logic [3:0] ADDR_MOD_CTRL = 4'h4;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
	// upper address bit selects the second group of four words
	localparam int ADDR_GROUP_BIT = 4;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int RXF_WAKEUP = 7;
	localparam int RXF_OVERRUN = 1;
	localparam int RXF_FULL = 0;
	localparam int TXF_ACK_LSB = 4;
	localparam int TXC_REQ_LSB = 4;
	localparam int ACC_MODE_LSB = 4;
	localparam int MOD_SOFT_RESET = 0;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RX_FLAGS_RESET = 8'h00;
	localparam logic [7:0] RX_IRQ_EN_RESET = 8'h00;
	localparam logic [2:0] TX_EMPTY_RESET = 3'h7;
	localparam logic [2:0] TX_ZERO_RESET = 3'h0;
	localparam logic [1:0] ACC_MODE_RESET = 2'h0;
	localparam logic [1:0] HIT_RESET = 2'h0;
	localparam logic MOD_SOFT_RESET_VALUE = 1'b1;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_ONE_32 = 2'b00,
		MODE_TWO_16 = 2'b01,
		MODE_FOUR_8 = 2'b10,
		MODE_CLOSED = 2'b11
	} acc_mode_e;

	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ANSWER = 1'b1
	} bus_state_e;

	// events from the protocol engine, one-cycle pulses
	typedef struct packed {
		logic wakeup;
		logic rxWarning;
		logic txWarning;
		logic rxPassive;
		logic txPassive;
		logic busOff;
		logic overrun;
		logic msgReceived;
		logic [1:0] msgHit;
		logic [2:0] txDone;
		logic [2:0] txAbortable;
	} can_events_s;

	// levels that say a status cause still holds
	typedef struct packed {
		logic wakeup;
		logic rxWarning;
		logic txWarning;
		logic rxPassive;
		logic txPassive;
		logic busOff;
	} can_causes_s;

	// interrupt request outputs
	typedef struct packed {
		logic wakeupIrq;
		logic errorIrq;
		logic rxIrq;
		logic txIrq;
	} can_irqs_s;

endpackage

//--- can_buffer_flags_properties.sv
// can_buffer_flags_properties: port-level checks of the buffer flag block
// assumes: bound to can_buffer_flags, one mclk domain, clkEn held high
`timescale 1ns/1ns
`default_nettype none
module can_buffer_flags_properties
	import can_flags_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// bus
	input wire logic read,
	input wire logic write,
	input wire logic waitrequest,
	// engine side
	input wire can_events_s events,
	input wire logic idMatch,
	input wire logic softResetMode,
	input wire logic [2:0] abortRequest,
	input wire logic [1:0] acceptanceMode,
	input wire logic foregroundLoad,
	input wire can_irqs_s irqs
);
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);

	wait_one_a: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("no answer one cycle after request");
	wait_single_a: assert property (!waitrequest |=> waitrequest)
		else $error("answer longer than one cycle");
	abort_clear_a: assert property (
		(abortRequest & (events.txDone | events.txAbortable)) != 3'h0
		|=> (abortRequest & ($past(events.txDone) | $past(events.txAbortable))) == 3'h0)
		else $error("abort request kept after empty set");
	abort_hold_a: assert property (
		(~abortRequest & $past(abortRequest) & ~($past(events.txDone)
		| $past(events.txAbortable))) == 3'h0 || softResetMode || $past(softResetMode))
		else $error("abort request dropped without grant");
	closed_mode_a: assert property (events.msgReceived && acceptanceMode == MODE_CLOSED
		|=> !foregroundLoad)
		else $error("closed filter reloaded foreground");
	id_match_a: assert property (events.msgReceived && !idMatch |=> !foregroundLoad)
		else $error("unmatched message copied");
	load_cause_a: assert property (foregroundLoad |-> $past(events.msgReceived))
		else $error("copy without received message");
	full_hold_a: assert property (irqs.rxIrq && !$past(write) && events.msgReceived
		|=> !foregroundLoad)
		else $error("copy while buffer full");
	soft_quiet_a: assert property (softResetMode [*3] |-> irqs == 4'h0 && abortRequest == 3'h0)
		else $error("state active in soft reset");
	acc_lock_a: assert property ($changed(acceptanceMode)
		|-> $past(write) && $past(softResetMode))
		else $error("acceptance mode changed outside soft reset");

	cover property (foregroundLoad);
	cover property ($fell(abortRequest[0]));
	cover property (irqs.errorIrq);
	cover property (irqs.wakeupIrq);
endmodule

bind can_buffer_flags can_buffer_flags_properties checker_inst (.mclk, .sys_rst, .read, .write,
	.waitrequest, .events, .idMatch, .softResetMode, .abortRequest, .acceptanceMode,
	.foregroundLoad, .irqs);
`default_nettype wire

//--- tb.sv
// tb: self-checking bench for can_buffer_flags
// assumes: one mclk domain, bus and events driven right after rising edges
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
	$display("unexpected at %0t: %h vs %h", $time, g, e); end end
module tb
	import can_flags_pkg::*;
;
	// ----------------------------------------------------------------
	// signals and instance
	// ----------------------------------------------------------------
	localparam logic [4:0] ARXF = {1'b0, ADDR_RX_FLAGS};
	localparam logic [4:0] AIEN = {1'b0, ADDR_RX_IRQ_EN};
	localparam logic [4:0] ATXF = {1'b0, ADDR_TX_FLAGS};
	localparam logic [4:0] ATXC = {1'b0, ADDR_TX_CTRL};
	localparam logic [4:0] AACC = {1'b1, ADDR_ACC_CTRL};
	localparam logic [4:0] AMOD = {1'b1, ADDR_MOD_CTRL};
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic read = 1'b0;
	logic write = 1'b0;
	logic idMatch = 1'b0;
	logic [4:0] address = 5'h00;
	logic [31:0] writedata = 32'h0;
	logic [7:0] q;
	logic [2:0] ab;
	can_irqs_s iq;
	can_events_s ev = '0;
	can_causes_s cs = '0;
	logic ld;
	int err_count = 0;
	int checks_done = 0;
	wire logic [31:0] readdata;
	wire logic waitrequest;
	wire logic softResetMode;
	wire logic foregroundLoad;
	wire logic [2:0] abortRequest;
	wire logic [1:0] acceptanceMode;
	can_irqs_s irqs;

	always #50 mclk = ~mclk;

	can_buffer_flags DUT (.mclk, .sys_rst, .clkEn(1'b1), .address, .read, .write, .writedata,
		.byteenable(4'hF), .readdata, .waitrequest, .events(ev), .causes(cs), .idMatch,
		.softResetMode, .abortRequest, .acceptanceMode, .foregroundLoad, .irqs);

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task test_done;
		$display("checks %0d, mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		int n;
		n = 0;
		read <= !w;
		write <= w;
		address <= a;
		writedata <= {24'h0, d};
		do begin
			@(posedge mclk);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		if (n >= 20) begin
			err_count++;
			test_done;
		end
		q = readdata[7:0];
		ab = abortRequest;
		iq = irqs;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge mclk);
	endtask

	task rdc(input logic [4:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		`CHK(q, e)
	endtask

	task pulse(input can_events_s e, input logic m);
		ev <= e;
		idMatch <= m;
		@(posedge mclk);
		ev <= '0;
		@(posedge mclk);
		ld = foregroundLoad;
		@(posedge mclk);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_acc;
		rdc(AMOD, 8'h01);
		rdc(ATXF, 8'h07);
		rdc(AIEN, 8'h00);
		rdc(ATXC, 8'h00);
		rdc(5'h1C, 8'h00);
		bus(1'b1, AACC, 8'h30);
		rdc(AACC, 8'h30);
		`CHK(acceptanceMode, 2'h3)
		bus(1'b1, AMOD, 8'h00);
		`CHK(softResetMode, 1'b0)
		pulse('{msgReceived: 1'b1, default: 0}, 1'b1);
		`CHK(ld, 1'b0)
		rdc(ARXF, 8'h00);
		bus(1'b1, AACC, 8'h00);
		rdc(AACC, 8'h30);
		$display("acceptance test done");
	endtask

	task t_tx;
		bus(1'b1, ATXC, 8'h07);
		rdc(ATXC, 8'h07);
		`CHK(iq.txIrq, 1'b1)
		bus(1'b1, ATXF, 8'h01);
		rdc(ATXF, 8'h06);
		bus(1'b1, ATXF, 8'h06);
		bus(1'b1, ATXC, 8'h17);
		bus(1'b1, ATXC, 8'h07);
		rdc(ATXC, 8'h17);
		`CHK(iq.txIrq, 1'b0)
		`CHK(ab, 3'h1)
		pulse('{txAbortable: 3'h1, default: 0}, 1'b0);
		rdc(ATXF, 8'h11);
		`CHK(ab, 3'h0)
		`CHK(iq.txIrq, 1'b1)
		bus(1'b1, ATXF, 8'h70);
		rdc(ATXF, 8'h11);
		bus(1'b1, ATXF, 8'h01);
		rdc(ATXF, 8'h00);
		pulse('{txDone: 3'h2, txAbortable: 3'h4, default: 0}, 1'b0);
		rdc(ATXF, 8'h02);
		$display("transmit test done");
	endtask

	task t_soft;
		bus(1'b1, AMOD, 8'h01);
		`CHK(softResetMode, 1'b1)
		rdc(ATXF, 8'h07);
		rdc(ATXC, 8'h00);
		bus(1'b1, AACC, 8'h00);
		bus(1'b1, AMOD, 8'h00);
		rdc(AACC, 8'h00);
		$display("soft reset test done");
	endtask

	task t_rx;
		bus(1'b1, AIEN, 8'h03);
		pulse('{msgReceived: 1'b1, msgHit: 2'h2, default: 0}, 1'b1);
		`CHK(ld, 1'b1)
		rdc(ARXF, 8'h01);
		`CHK(iq.rxIrq, 1'b1)
		`CHK(iq.errorIrq, 1'b0)
		rdc(AACC, 8'h02);
		pulse('{msgReceived: 1'b1, msgHit: 2'h1, default: 0}, 1'b1);
		`CHK(ld, 1'b0)
		rdc(AACC, 8'h02);
		rdc(ARXF, 8'h03);
		`CHK(iq.errorIrq, 1'b1)
		bus(1'b1, ARXF, 8'h00);
		rdc(ARXF, 8'h03);
		bus(1'b1, ARXF, 8'h03);
		rdc(ARXF, 8'h00);
		`CHK(iq, 4'h0)
		pulse('{msgReceived: 1'b1, default: 0}, 1'b0);
		`CHK(ld, 1'b0)
		rdc(ARXF, 8'h00);
		$display("receive test done");
	endtask

	task t_err;
		bus(1'b1, AIEN, 8'h84);
		cs <= '{wakeup: 1'b1, default: 0};
		pulse('{wakeup: 1'b1, busOff: 1'b1, default: 0}, 1'b0);
		rdc(ARXF, 8'h84);
		`CHK(iq.wakeupIrq, 1'b1)
		`CHK(iq.errorIrq, 1'b1)
		bus(1'b1, ARXF, 8'h84);
		rdc(ARXF, 8'h80);
		`CHK(iq.wakeupIrq, 1'b1)
		cs <= '0;
		bus(1'b1, ARXF, 8'h80);
		rdc(ARXF, 8'h00);
		`CHK(iq, 4'h0)
		$display("error flag test done");
	endtask

	initial begin
		repeat (8) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		t_acc;
		t_tx;
		t_soft;
		t_rx;
		t_err;
		test_done;
	end
endmodule
`default_nettype wire
